// ### hbridge_fault_pkg.sv
// types shared by the h-bridge fault protection block
package hbridge_fault_pkg;

   typedef enum logic [1:0] {
      MODE_STANDBY,
      MODE_FORWARD,
      MODE_REVERSE,
      MODE_BRAKE
   } mode_t;

   // sampled pins: mode inputs and digitised comparator results
   typedef struct packed {
      logic modeInFwd;
      logic modeInRev;
      logic supplyBelowLow;
      logic supplyAboveHigh;
      logic overCurrent;
      logic shortToGround;
      logic shortToSupply;
      logic shortOutputs;
      logic tempAboveLimit;
      logic tempBelowRecover;
   } pins_t;

   // power switch gates: a/b are bridge_out_a/bridge_out_b sides
   typedef struct packed {
      logic highA;
      logic lowA;
      logic highB;
      logic lowB;
   } gates_t;

   typedef struct packed {
      logic supplyLockout;
      logic overcurrentGuard;
      logic shortCircuitGuard;
      logic overTemp;
      logic sleep;
   } status_t;

endpackage : hbridge_fault_pkg

// ### hbridge_fault_protection.sv
// h-bridge fault protection controller: lockout, over-current, short, over-temp, sleep
`timescale 1ns/100ps
`include "hbridge_fault_protection_defs.svh"

module hbridge_fault_protection #(
   parameter int unsigned SLEEP_CYCLES = `HFP_SLEEP_CYCLES,
   parameter int unsigned DEGLITCH_CYCLES = `HFP_DEGLITCH_CYCLES,
   parameter int unsigned RETRY_CYCLES = `HFP_RETRY_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // pins from outside the clock domain
   input wire hbridge_fault_pkg::pins_t pinsIn,
   // bridge switches and status
   output hbridge_fault_pkg::gates_t gates,
   output hbridge_fault_pkg::status_t status
);

   localparam int CW = `HFP_COUNT_WIDTH;
   localparam logic [CW-1:0] SLEEP_LAST = CW'(SLEEP_CYCLES - 1);
   localparam logic [CW-1:0] DEGL_LIMIT = CW'(DEGLITCH_CYCLES);
   localparam logic [CW-1:0] RETRY_LAST = CW'(RETRY_CYCLES - 1);

   typedef struct packed {
      hbridge_fault_pkg::pins_t sync1;
      hbridge_fault_pkg::pins_t sync2;
      logic [CW-1:0] sleepCnt;
      logic [CW-1:0] deglCnt;
      logic [CW-1:0] retryCnt;
      hbridge_fault_pkg::gates_t gates;
      hbridge_fault_pkg::status_t status;
   } state_t;

   state_t q;
   state_t d;
   hbridge_fault_pkg::mode_t mode;
   logic driveMode;
   logic guardEn;
   logic shortNow;
   logic ocTrip;
   logic faultOff;

   always_comb begin
      d = q;
      d.sync1 = pinsIn;
      d.sync2 = q.sync1;

      case ({q.sync2.modeInFwd, q.sync2.modeInRev})
         2'b10: mode = hbridge_fault_pkg::MODE_FORWARD;
         2'b01: mode = hbridge_fault_pkg::MODE_REVERSE;
         2'b11: mode = hbridge_fault_pkg::MODE_BRAKE;
         default: mode = hbridge_fault_pkg::MODE_STANDBY;
      endcase
      driveMode = (mode == hbridge_fault_pkg::MODE_FORWARD) ||
                  (mode == hbridge_fault_pkg::MODE_REVERSE);

      // sleep period after a long standby or brake
      if (driveMode) begin
         d.status.sleep = 1'b0;
         d.sleepCnt = '0;
      end else if (!q.status.sleep) begin
         if (q.sleepCnt == SLEEP_LAST) begin
            d.status.sleep = 1'b1;
            d.sleepCnt = '0;
         end else begin
            d.sleepCnt = q.sleepCnt + 1'b1;
         end
      end

      // lockout hysteresis between the two comparators
      if (q.sync2.supplyBelowLow) begin
         d.status.supplyLockout = 1'b1;
      end else if (q.sync2.supplyAboveHigh) begin
         d.status.supplyLockout = 1'b0;
      end

      // current guards live in drive and brake, never in standby or sleep;
      // next sleep is used so no guard is left set on the edge that enters sleep
      guardEn = !d.status.sleep && (mode != hbridge_fault_pkg::MODE_STANDBY);
      shortNow = q.sync2.shortToGround | q.sync2.shortToSupply |
                 q.sync2.shortOutputs;

      // over-current must hold past the deglitch count before it trips
      if (guardEn && q.sync2.overCurrent) begin
         if (q.deglCnt != DEGL_LIMIT) begin
            d.deglCnt = q.deglCnt + 1'b1;
         end
      end else begin
         d.deglCnt = '0;
      end
      ocTrip = guardEn && q.sync2.overCurrent && (q.deglCnt == DEGL_LIMIT);

      if (!guardEn) begin
         d.status.overcurrentGuard = 1'b0;
         d.status.shortCircuitGuard = 1'b0;
         d.retryCnt = '0;
      end else begin
         if (q.status.overcurrentGuard || q.status.shortCircuitGuard) begin
            if (driveMode) begin
               if (q.retryCnt == RETRY_LAST) begin
                  d.retryCnt = '0;
                  d.status.overcurrentGuard = 1'b0;
                  d.status.shortCircuitGuard = shortNow;
               end else begin
                  d.retryCnt = q.retryCnt + 1'b1;
               end
            end else begin
               // brake: no timer, release once the fault is gone
               d.retryCnt = '0;
               if (!q.sync2.overCurrent) begin
                  d.status.overcurrentGuard = 1'b0;
               end
               if (!shortNow) begin
                  d.status.shortCircuitGuard = 1'b0;
               end
            end
         end
         // a new trip wins over a release in the same cycle
         if (ocTrip && !q.status.overcurrentGuard && !q.status.shortCircuitGuard) begin
            d.retryCnt = '0;
         end
         if (ocTrip) begin
            d.status.overcurrentGuard = 1'b1;
         end
         if (shortNow && !q.status.shortCircuitGuard && !q.status.overcurrentGuard) begin
            d.retryCnt = '0;
         end
         if (shortNow && !q.status.shortCircuitGuard) begin
            d.status.shortCircuitGuard = 1'b1;
         end
      end

      // over-temperature also guards standby, but not sleep
      if (d.status.sleep) begin
         d.status.overTemp = 1'b0;
      end else if (q.sync2.tempAboveLimit) begin
         d.status.overTemp = 1'b1;
      end else if (q.sync2.tempBelowRecover) begin
         d.status.overTemp = 1'b0;
      end

      // gates follow next-state faults so a trip opens the bridge at once
      faultOff = d.status.supplyLockout | d.status.overcurrentGuard |
                 d.status.shortCircuitGuard | d.status.overTemp;
      d.gates = '0;
      if (!faultOff) begin
         case (mode)
            hbridge_fault_pkg::MODE_FORWARD: begin
               d.gates.highA = 1'b1;
               d.gates.lowB = 1'b1;
            end
            hbridge_fault_pkg::MODE_REVERSE: begin
               d.gates.lowA = 1'b1;
               d.gates.highB = 1'b1;
            end
            hbridge_fault_pkg::MODE_BRAKE: begin
               d.gates.lowA = 1'b1;
               d.gates.lowB = 1'b1;
            end
            default: d.gates = '0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
         q.status.supplyLockout <= `HFP_LOCKOUT_RESET;
      end else begin
         q <= d;
      end
   end

   assign gates = q.gates;
   assign status = q.status;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   AST_LOCKOUT_OFF: assert property (status.supplyLockout |-> gates == '0)
      else $error("bridge driven during supply lockout");
   AST_LOCKOUT_RELEASE: assert property (
      q.sync2.supplyAboveHigh && !q.sync2.supplyBelowLow |=> !status.supplyLockout)
      else $error("lockout not released above upper threshold");
   AST_LOCKOUT_ENTER: assert property (q.sync2.supplyBelowLow |=> status.supplyLockout)
      else $error("lockout not entered below lower threshold");
   AST_OC_TRIP: assert property (
      guardEn && q.sync2.overCurrent && q.deglCnt == DEGL_LIMIT
      |=> status.overcurrentGuard && gates == '0)
      else $error("over-current past deglitch did not open bridge");
   AST_OC_FILTER: assert property (
      !status.overcurrentGuard && q.deglCnt < DEGL_LIMIT |=> !status.overcurrentGuard)
      else $error("over-current tripped before deglitch interval");
   AST_RETRY_RELEASE: assert property (
      status.overcurrentGuard && driveMode && guardEn && q.retryCnt == RETRY_LAST && !ocTrip
      |=> !status.overcurrentGuard)
      else $error("over-current not released at retry expiry");
   AST_NO_RETRY_BRAKE: assert property (
      mode == hbridge_fault_pkg::MODE_BRAKE |=> q.retryCnt == '0)
      else $error("retry timer ran in brake");
   AST_SHORT_FAST: assert property (guardEn && shortNow |=> status.shortCircuitGuard)
      else $error("short not acted on at once");
   AST_SHORT_HOLD: assert property (
      status.shortCircuitGuard && guardEn && driveMode && q.retryCnt == RETRY_LAST && shortNow
      |=> status.shortCircuitGuard)
      else $error("short released while still present");
   AST_TEMP: assert property (!d.status.sleep && q.sync2.tempAboveLimit |=> gates == '0)
      else $error("bridge driven while over temperature");
   AST_SLEEP_NO_GUARD: assert property (status.sleep |-> !status.overTemp)
      else $error("protection active in sleep");
   AST_SLEEP_NO_CURRENT: assert property (
      status.sleep |-> !status.overcurrentGuard && !status.shortCircuitGuard)
      else $error("current guard active in sleep");
   AST_SLEEP_EXIT: assert property (driveMode |=> !status.sleep)
      else $error("drive command did not leave sleep");

   COV_OC_RETRY: cover property (status.overcurrentGuard ##1 !status.overcurrentGuard);
   COV_SHORT: cover property (status.shortCircuitGuard && driveMode);
   COV_SLEEP: cover property (!status.sleep ##1 status.sleep);
   COV_TEMP: cover property (status.overTemp ##1 !status.overTemp);
   COV_BRAKE_HOLD: cover property (status.overcurrentGuard && mode == hbridge_fault_pkg::MODE_BRAKE);

endmodule : hbridge_fault_protection

// ### hbridge_fault_protection_defs.svh
// timing constants and reset values for the h-bridge fault protection block
// Summary of operation
// - supply lockout: outputs off, mode inputs ignored
// - above upper threshold, mode inputs drive bridge
// - below lower threshold, lockout re-entered with hysteresis
// - over-current past deglitch interval switches all off
// - over-current retry timer expiry resumes normal drive
// - timed retry only in forward or reverse
// - short-circuit acts with no deglitch filtering
// - short-circuit rechecked each retry interval until gone
// - ground, supply, output-to-output shorts all count
// - over-temperature off until recovery level reached
// - guards enabled per mode, none in sleep
// - two mode inputs select standby/forward/reverse/brake
// - idle beyond 10ms enters sleep; drive exits
`ifndef HBRIDGE_FAULT_PROTECTION_DEFS_SVH
`define HBRIDGE_FAULT_PROTECTION_DEFS_SVH

`define HFP_CLOCK_MHZ 40
`define HFP_COUNT_WIDTH 24
// idle time before the sleep period, in microseconds
`define HFP_SLEEP_DELAY_US 10000
`define HFP_SLEEP_CYCLES (`HFP_SLEEP_DELAY_US * `HFP_CLOCK_MHZ)
// deglitch and retry intervals, in nanoseconds
`define HFP_DEGLITCH_NS 2000
`define HFP_RETRY_NS 100000
`define HFP_DEGLITCH_CYCLES ((`HFP_DEGLITCH_NS * `HFP_CLOCK_MHZ) / 1000)
`define HFP_RETRY_CYCLES ((`HFP_RETRY_NS * `HFP_CLOCK_MHZ) / 1000)
// bridge locked out from power-on until the supply proves good
`define HFP_LOCKOUT_RESET 1'b1

`endif

// ### hbridge_fault_protection_test.sv
// self-checking bench for the h-bridge fault protection block
`timescale 1ns/100ps
module hbridge_fault_protection_test;
   // short counts keep the run brief; sleep stays well above the idle phases
   localparam int DEG = 8;
   localparam int RET = 30;
   localparam int SLP = 200;
   localparam hbridge_fault_pkg::mode_t SB = hbridge_fault_pkg::MODE_STANDBY;
   localparam hbridge_fault_pkg::mode_t FW = hbridge_fault_pkg::MODE_FORWARD;
   localparam hbridge_fault_pkg::mode_t RV = hbridge_fault_pkg::MODE_REVERSE;
   localparam hbridge_fault_pkg::mode_t BR = hbridge_fault_pkg::MODE_BRAKE;
   typedef struct {
      hbridge_fault_pkg::mode_t m;
      logic [7:0] f;
      logic [3:0] g;
      logic [4:0] s;
   } row_t;
   logic clock;
   logic arst_n;
   logic fwd;
   logic rev;
   logic [7:0] f;
   hbridge_fault_pkg::mode_t md;
   hbridge_fault_pkg::pins_t pins;
   hbridge_fault_pkg::gates_t gates;
   hbridge_fault_pkg::status_t status;
   int miscompares = 0;
   int checkCount = 0;
   int k;
   int n;
   row_t rows [11] = '{'{FW, 8'h41, 4'h9, 5'h00}, '{RV, 8'h41, 4'h6, 5'h00},
      '{BR, 8'h41, 4'h5, 5'h00}, '{SB, 8'h41, 4'h0, 5'h00}, '{FW, 8'h42, 4'h0, 5'h02},
      '{FW, 8'h40, 4'h0, 5'h02}, '{FW, 8'h41, 4'h9, 5'h00}, '{FW, 8'h01, 4'h9, 5'h00},
      '{FW, 8'h81, 4'h0, 5'h10}, '{FW, 8'h01, 4'h0, 5'h10}, '{FW, 8'h41, 4'h9, 5'h00}};

   assign pins = {fwd, rev, f};

   hbridge_host_model hbridge_host_model_i (.mode(md), .fwd(fwd), .rev(rev));
   hbridge_fault_protection #(.SLEEP_CYCLES(SLP), .DEGLITCH_CYCLES(DEG), .RETRY_CYCLES(RET))
      hbridge_fault_protection_i (.clock(clock), .arst_n(arst_n), .pinsIn(pins),
      .gates(gates), .status(status));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize

   task automatic chkG(input string nm, input hbridge_fault_pkg::gates_t e);
      checkCount++;
      if (gates !== e) begin
         miscompares++;
         $display("[FAIL] %s exp %h got %h", nm, e, gates);
      end
   endtask : chkG

   task automatic chkS(input string nm, input hbridge_fault_pkg::status_t e);
      checkCount++;
      if (status !== e) begin
         miscompares++;
         $display("[FAIL] %s exp %h got %h", nm, e, status);
      end
   endtask : chkS

   task automatic chkT(input string nm, input int lo, input int hi, input int got);
      checkCount++;
      if (got < lo || got > hi) begin
         miscompares++;
         $display("[FAIL] %s exp %0d..%0d got %0d", nm, lo, hi, got);
      end
   endtask : chkT

   task automatic drive(input hbridge_fault_pkg::mode_t m, input logic [7:0] v, input int c);
      @(negedge clock);
      md = m;
      f = v;
      repeat (c) @(negedge clock);
   endtask : drive

   task automatic waitBit(input int b, input logic v, input int lim, output int c);
      c = 0;
      while (status[b] !== v && c < lim) begin
         @(negedge clock);
         c++;
      end
   endtask : waitBit

   initial begin
      repeat (5000) @(posedge clock);
      miscompares++;
      summarize();
   end

   initial begin
      arst_n = 1'b0;
      md = SB;
      f = 8'h00;
      repeat (8) @(negedge clock);
      chkG("reset gates", 4'h0);
      chkS("reset status", 5'h10);
      arst_n = 1'b1;
      drive(FW, 8'h01, 5);
      chkG("early lockout", 4'h0);
      foreach (rows[i]) begin
         drive(rows[i].m, rows[i].f, 5);
         chkG("row gates", rows[i].g);
         chkS("row status", rows[i].s);
      end
      drive(FW, 8'h61, DEG - 2);
      drive(FW, 8'h41, 5);
      chkS("glitch ignored", 5'h00);
      drive(FW, 8'h61, 0);
      waitBit(3, 1'b1, 40, k);
      chkT("trip delay", DEG + 1, DEG + 5, k);
      chkG("trip gates", 4'h0);
      drive(FW, 8'h41, 0);
      waitBit(3, 1'b0, RET + 20, k);
      chkT("retry delay", RET - 4, RET + 5, k);
      drive(FW, 8'h41, 2);
      chkG("resume", 4'h9);
      for (int i = 0; i < 3; i++) begin
         drive(FW, 8'h41 | (8'h10 >> i), 0);
         waitBit(2, 1'b1, 10, k);
         chkT("short delay", 1, 4, k);
         chkG("short gates", 4'h0);
         drive(FW, 8'h41 | (8'h10 >> i), RET + 5);
         chkS("short held", 5'h04);
         drive(FW, 8'h41, 0);
         waitBit(2, 1'b0, RET + 10, k);
         drive(FW, 8'h41, 2);
         chkG("short gone", 4'h9);
      end
      drive(BR, 8'h61, 0);
      waitBit(3, 1'b1, 30, k);
      n = 0;
      repeat (RET + 10) begin
         @(negedge clock);
         if (status[3] !== 1'b1) n++;
      end
      chkT("brake no retry", 0, 0, n);
      drive(BR, 8'h41, 5);
      chkG("brake release", 4'h5);
      drive(SB, 8'h62, DEG + 8);
      chkS("standby guards", 5'h02);
      drive(SB, 8'h41, SLP + 10);
      chkS("sleep entry", 5'h01);
      drive(SB, 8'h62, 5);
      chkS("sleep no guard", 5'h01);
      drive(BR, 8'h41, 5);
      chkG("sleep brake", 4'h5);
      drive(FW, 8'h41, 5);
      chkS("wake", 5'h00);
      chkG("wake gates", 4'h9);
      summarize();
   end
endmodule : hbridge_fault_protection_test

// ### hbridge_host_model.sv
// host-side model that turns a mode command into the two mode pins
`timescale 1ns/100ps
module hbridge_host_model (
   // mode command
   input wire hbridge_fault_pkg::mode_t mode,
   // mode pins
   output logic fwd,
   output logic rev
);
   assign fwd = mode[0];
   assign rev = mode[1];
endmodule : hbridge_host_model
